/* include/irq_agg_pkg.sv */
// Purpose: Shared constants and carrier types for the interrupt aggregator.
// Assumes: 250 MHz sys_clk; register addresses and commands are 3-bit codes.
// Notes:   Source bit order matches the packed field order of src_t.
package irq_agg_pkg;

  localparam int CLK_MHZ        = 250;
  localparam int IRQ_TIMEOUT_MS = 6;
  localparam int T_INT_MIN_US   = 10;
  // Longest time rounds down and least time rounds up; both are exact at 250 MHz.
  localparam int IRQ_TIMEOUT_CYC = IRQ_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int MIN_PULSE_CYC   = T_INT_MIN_US * CLK_MHZ;
  localparam int CNT_W           = 21;

  localparam int NSRC = 15;
  localparam int DW   = 8;

  localparam logic [2:0] CMD_READ_ONLY = 3'h7;
  localparam logic [2:0] ADDR_WAKE     = 3'h0;
  localparam logic [2:0] ADDR_FAIL_A   = 3'h1;
  localparam logic [2:0] ADDR_FAIL_B   = 3'h2;

  // Source groups per register and the position of the summary flag.
  localparam int WAKE_LO  = 0;
  localparam int WAKE_HI  = 3;
  localparam int FAILA_LO = 4;
  localparam int FAILA_HI = 8;
  localparam int FAILB_LO = 9;
  localparam int FAILB_HI = 14;
  localparam int SUM_BIT  = 7;

  localparam int REG2_UV_IDX = 9;
  localparam int REG3_UV_IDX = 10;

  // Sources whose bit turns into the live state once read, and dual-edge sources.
  localparam logic [NSRC-1:0] LATCH_STATE_MASK = 15'h0FF0;
  localparam logic [NSRC-1:0] DUAL_EDGE_MASK   = 15'h0600;
  localparam logic [NSRC-1:0] MASK_RESET       = 15'h7FFF;

  typedef struct packed {
    logic bad_watchdog_cfg_flag;
    logic reset_evt_flag;
    logic spi_corrupt_flag;
    logic reg3_overcurrent_flag;
    logic reg3_undervolt_flag;
    logic reg2_undervolt_flag;
    logic lin_fail_flag;
    logic can_fail_flag;
    logic can_xcvr_overtemp_flag;
    logic reg2_overtemp_flag;
    logic reg1_overtemp_warn_flag;
    logic periodic_wake_flag;
    logic pin_wake_flag;
    logic lin_wake_flag;
    logic can_wake_flag;
  } src_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] cmd;
    logic [2:0] addr;
  } rd_req_t;

  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_GAP} irq_state_t;

endpackage

/* rtl/irq_src_cell.sv */
// Purpose: One interrupt source: edge detection, status latch and clear.
// Assumes: live is synchronous to sys_clk; clear is a one-cycle pulse.
// Notes:   A set in the same cycle as a clear wins.
`timescale 1ns/100ps
`default_nettype none
module irq_src_cell #(
  parameter bit LATCH_STATE = 1'b0,
  parameter bit DUAL_EDGE   = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic live,
  input  wire logic force_set,
  input  wire logic suppress,
  input  wire logic clear,
  output logic      fire,
  output logic      status
);
  logic live_q;
  logic latch_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      live_q <= 1'b0;
    end else begin
      live_q <= live;
    end
  end

  always_comb begin
    fire = force_set | (~suppress & (live ^ live_q) & (DUAL_EDGE | live));
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      latch_q <= 1'b0;
    end else if (fire) begin
      latch_q <= 1'b1;
    end else if (clear) begin
      latch_q <= 1'b0;
    end
  end

  // A held condition keeps the bit set through reads, as a shorted regulator must.
  assign status = LATCH_STATE ? (latch_q | live) : latch_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  chk_uv_dual: assert property (DUAL_EDGE && !suppress && !$past(srst) && $fell(live) |-> fire)
    else $error("falling undervoltage did not fire");
  chk_latch_hold: assert property (LATCH_STATE && latch_q && !clear |=> status)
    else $error("latched state bit dropped before read");
  chk_event_clear: assert property (!LATCH_STATE && clear && !fire |=> !status)
    else $error("event bit not cleared by read");
  chk_switchoff_quiet: assert property (suppress && !force_set |-> !fire)
    else $error("interrupt fired during regulator switch-off");
  chk_switch_on: assert property (force_set |=> status ##1 (status || $past(clear)))
    else $error("switch-on did not set status");
endmodule
`default_nettype wire

/* rtl/irq_aggregator.sv */
// Purpose: Interrupt aggregation, read-clear and interrupt pin sequencing.
// Assumes: Source and read-request inputs are synchronous to sys_clk.
// Notes:   The pin is open drain; it is never driven high, only released.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Pin driven low when any enabled source fires while irq_allowed is high.
// - Mask bit 0 blocks the pin but status still sets and reads.
// - Undervoltage sources raise an interrupt on appearing and disappearing.
// - Temperature, comms, regulator bits latch until read, then show live state.
// - Internal failure and wake bits are event-only, cleared by read.
// - Pin released on read-only access to register 000 or on time-out.
// - Wake bits in register 000; other causes set summary flag there.
// - Read-only command clears event bits returned by that read.
// - Summary flag is 0 only when registers 001 and 010 are all zero.
// - In init before reset release, the pin is sampled as config input.
// - No undervoltage interrupt while that regulator is switching off.
// - Regulator switch-on command sets its undervoltage bit and interrupts.
// - Read does not clear switch-on bit while output stays under threshold.
// - Shorted regulator keeps its switch-on bit set across reads.
// - Several events before a read give one low pulse, all reported.
// - Low at most the time-out; activations spaced by time-out; events kept.
// - Each low pulse lasts at least 10 us.
module irq_aggregator
  import irq_agg_pkg::*;
#(
  parameter int unsigned IRQ_TIMEOUT_CYCLES = irq_agg_pkg::IRQ_TIMEOUT_CYC
) (
  input  wire logic                        sys_clk,
  input  wire logic                        srst,
  input  wire irq_agg_pkg::src_t           src,
  input  wire irq_agg_pkg::src_t           src_enable,
  input  wire logic [1:0]                  reg_switch_on,
  input  wire logic [1:0]                  reg_switching_off,
  input  wire logic                        irq_allowed,
  input  wire logic                        init_mode,
  input  wire logic                        reset_out_n,
  input  wire irq_agg_pkg::rd_req_t        rd_req,
  input  wire logic                        int_pin_in,
  output logic [irq_agg_pkg::DW-1:0]       rd_data_q,
  output logic                             rd_valid_q,
  output logic                             int_pin_out_q,
  output logic                             int_pin_oe_q,
  output logic                             cfg_group_q
);
  import irq_agg_pkg::*;

  localparam logic [CNT_W-1:0] TO_LAST  = CNT_W'(IRQ_TIMEOUT_CYCLES - 1);
  localparam logic [CNT_W-1:0] MIN_LAST = CNT_W'(MIN_PULSE_CYC - 1);

  function automatic logic [NSRC-1:0] group_of(input logic [2:0] addr);
    logic [NSRC-1:0] g;
    g = '0;
    case (addr)
      ADDR_WAKE: begin
        for (int i = WAKE_LO; i <= WAKE_HI; i++) g[i] = 1'b1;
      end
      ADDR_FAIL_A: begin
        for (int i = FAILA_LO; i <= FAILA_HI; i++) g[i] = 1'b1;
      end
      ADDR_FAIL_B: begin
        for (int i = FAILB_LO; i <= FAILB_HI; i++) g[i] = 1'b1;
      end
      default: g = '0;
    endcase
    return g;
  endfunction

  logic [NSRC-1:0] live;
  logic [NSRC-1:0] fire;
  logic [NSRC-1:0] status;
  logic [NSRC-1:0] force_set;
  logic [NSRC-1:0] suppress;
  logic [NSRC-1:0] clear;
  logic [NSRC-1:0] fire_en;
  logic            read_only;
  logic            rel_read;
  logic            summary;

  assign live = src;
  assign read_only = rd_req.valid && (rd_req.cmd == CMD_READ_ONLY);
  assign rel_read = read_only && (rd_req.addr == ADDR_WAKE);
  assign clear = read_only ? group_of(rd_req.addr) : '0;

  always_comb begin
    force_set = '0;
    suppress  = '0;
    force_set[REG2_UV_IDX] = reg_switch_on[0];
    force_set[REG3_UV_IDX] = reg_switch_on[1];
    suppress[REG2_UV_IDX]  = reg_switching_off[0];
    suppress[REG3_UV_IDX]  = reg_switching_off[1];
  end

  generate
    for (genvar i = 0; i < NSRC; i++) begin : g_src
      irq_src_cell #(
        .LATCH_STATE (LATCH_STATE_MASK[i]),
        .DUAL_EDGE   (DUAL_EDGE_MASK[i])
      ) u_cell (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .live      (live[i]),
        .force_set (force_set[i]),
        .suppress  (suppress[i]),
        .clear     (clear[i]),
        .fire      (fire[i]),
        .status    (status[i])
      );
    end
  endgenerate

  // Masking gates only the pin; the status bits above are unaffected.
  assign fire_en = fire & src_enable;
  assign summary = |status[FAILB_HI:FAILA_LO];

  // Read data path, sampled before the clear takes effect.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_req.valid;
      if (rd_req.valid) begin
        case (rd_req.addr)
          ADDR_WAKE:   rd_data_q <= {summary, 3'h0, status[WAKE_HI:WAKE_LO]};
          ADDR_FAIL_A: rd_data_q <= {3'h0, status[FAILA_HI:FAILA_LO]};
          ADDR_FAIL_B: rd_data_q <= {2'h0, status[FAILB_HI:FAILB_LO]};
          default:     rd_data_q <= 8'h00;
        endcase
      end
    end
  end

  irq_state_t       state_q;
  irq_state_t       state_d;
  logic [CNT_W-1:0] cnt_q;
  logic             pending_q;
  logic             rel_seen_q;
  logic             start;

  assign start = (state_q == ST_IDLE) && (state_d == ST_LOW);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (pending_q && irq_allowed) state_d = ST_LOW;
      end
      ST_LOW: begin
        if ((rel_seen_q && cnt_q >= MIN_LAST) || cnt_q == TO_LAST) state_d = ST_GAP;
      end
      ST_GAP: begin
        if (cnt_q == TO_LAST) state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || state_d != state_q) begin
      cnt_q <= '0;
    end else if (state_q != ST_IDLE) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // Events during the gap are held and signalled once it ends; events while
  // the pin is already low share the running pulse. An event in the cycle the
  // pulse starts rides on that pulse, so the start clear takes priority here.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pending_q <= 1'b0;
    end else if (start) begin
      pending_q <= 1'b0;
    end else if (|fire_en && irq_allowed && state_q != ST_LOW) begin
      pending_q <= 1'b1;
    end
  end

  // A release read that comes early is remembered until the minimum width passes.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rel_seen_q <= 1'b0;
    end else if (rel_read && state_q == ST_LOW) begin
      rel_seen_q <= 1'b1;
    end else if (state_q != ST_LOW) begin
      rel_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      int_pin_oe_q  <= 1'b0;
      int_pin_out_q <= 1'b0;
    end else begin
      int_pin_oe_q  <= (state_d == ST_LOW);
      int_pin_out_q <= 1'b0;
    end
  end

  // The strap is taken by a clocked sample, so it is never a reset value.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg_group_q <= 1'b0;
    end else if (init_mode && !reset_out_n) begin
      cfg_group_q <= int_pin_in;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_fresh_event;
    (|fire_en) && irq_allowed && state_q == ST_IDLE && !pending_q;
  endsequence
  sequence s_release;
    !$past(srst) && $fell(int_pin_oe_q);
  endsequence

  chk_pin_low_event: assert property (s_fresh_event ##1 irq_allowed |=> int_pin_oe_q)
    else $error("enabled event did not pull the pin low");
  chk_masked_quiet: assert property ((|fire) && !(|fire_en) && !pending_q |=> !pending_q)
    else $error("masked source raised an interrupt");
  chk_timeout_rel: assert property (state_q == ST_LOW && cnt_q == TO_LAST |=> !int_pin_oe_q)
    else $error("pin stayed low past the time-out");
  chk_min_width: assert property (s_release |-> $past(cnt_q) >= MIN_LAST)
    else $error("low pulse shorter than minimum");
  chk_gap_spacing: assert property (s_release |=> !int_pin_oe_q[*8])
    else $error("pin reasserted inside the gap");
  chk_summary_flag: assert property (rd_req.valid && rd_req.addr == ADDR_WAKE
                                     |=> rd_data_q[SUM_BIT] == $past(summary))
    else $error("summary flag mismatch");
  chk_read_release: assert property (state_q == ST_LOW && rel_seen_q && cnt_q >= MIN_LAST
                                     |=> !int_pin_oe_q)
    else $error("read-only access did not release the pin");
  chk_single_pulse: assert property (state_q == ST_LOW && (|fire_en) |=> !pending_q)
    else $error("event during low pulse queued a second pulse");
endmodule
`default_nettype wire

/* dv/host_model.sv */
// Purpose: Host microcontroller side of the interrupt aggregator.
// Assumes: One read-only access at a time; the pin has a pull resistor.
// Notes:   Request fields are scrambled while idle so stale values never look valid.
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic                      sys_clk,
  input  wire logic                      pin_oe,
  input  wire logic                      pull_level,
  input  wire logic [irq_agg_pkg::DW-1:0] rd_data,
  input  wire logic                      rd_valid,
  output var  irq_agg_pkg::rd_req_t      rd_req,
  output logic                           pin_level
);
  import irq_agg_pkg::*;

  // Open drain: the device only pulls low, otherwise the resistor sets the level.
  assign pin_level = pin_oe ? 1'b0 : pull_level;

  initial begin
    rd_req = '0;
  end

  task automatic access(input logic [2:0] c, input logic [2:0] a, output logic [DW-1:0] d,
                        output logic ok);
    @(posedge sys_clk);
    rd_req <= '{valid: 1'b1, cmd: c, addr: a};
    @(posedge sys_clk);
    rd_req <= '{valid: 1'b0, cmd: ~CMD_READ_ONLY, addr: ~a};
    #1;
    ok = rd_valid;
    d = rd_data;
  endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Purpose: Self-checking bench for the interrupt aggregator.
// Assumes: Time-out shortened to 3000 cycles; the host model performs all reads.
// Notes:   Status bits are predicted by a small model kept beside the stimulus.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import irq_agg_pkg::*;
  localparam int TO = 3000;
  logic            sys_clk, srst, allowed, init, reset_out_n, strap, pin_in;
  logic [NSRC-1:0] src_v, en_v, lat_m;
  logic [1:0]      sw_on, sw_off;
  logic [DW-1:0]   rd_data;
  logic            rd_valid, out_q, oe, cfg;
  rd_req_t         req;
  int              fail_count = 0;
  int              tests_run = 0;
  int              cyc = 0;
  int              t0, n;
  logic [31:0]     seed;

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  irq_aggregator #(.IRQ_TIMEOUT_CYCLES(TO)) u_dut (
    .sys_clk(sys_clk), .srst(srst), .src(src_t'(src_v)), .src_enable(src_t'(en_v)),
    .reg_switch_on(sw_on), .reg_switching_off(sw_off), .irq_allowed(allowed),
    .init_mode(init), .reset_out_n(reset_out_n), .rd_req(req), .int_pin_in(pin_in),
    .rd_data_q(rd_data), .rd_valid_q(rd_valid), .int_pin_out_q(out_q),
    .int_pin_oe_q(oe), .cfg_group_q(cfg));

  host_model u_host (
    .sys_clk(sys_clk), .pin_oe(oe), .pull_level(strap), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_req(req), .pin_level(pin_in));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction

  // Predicts the word from latches plus live state, then clears that group on a read-only command.
  task automatic rd(input logic [2:0] a, input logic [2:0] c = CMD_READ_ONLY);
    logic [NSRC-1:0] v;
    logic [DW-1:0]   e, d;
    logic            ok;
    v = lat_m | (src_v & LATCH_STATE_MASK);
    case (a)
      ADDR_WAKE:   e = {|v[FAILB_HI:FAILA_LO], 3'h0, v[WAKE_HI:WAKE_LO]};
      ADDR_FAIL_A: e = {3'h0, v[FAILA_HI:FAILA_LO]};
      ADDR_FAIL_B: e = {2'h0, v[FAILB_HI:FAILB_LO]};
      default:     e = '0;
    endcase
    u_host.access(c, a, d, ok);
    chk({31'h0, ok}, 32'h1);
    chk({24'h0, d}, {24'h0, e});
    // Only the read-only command clears; any other access leaves the bits alone.
    if (c == CMD_READ_ONLY) begin
      if (a == ADDR_WAKE) lat_m[WAKE_HI:WAKE_LO] = '0;
      if (a == ADDR_FAIL_A) lat_m[FAILA_HI:FAILA_LO] = '0;
      if (a == ADDR_FAIL_B) lat_m[FAILB_HI:FAILB_LO] = '0;
    end
  endtask

  task automatic set_src(input logic [NSRC-1:0] nv);
    logic [NSRC-1:0] ch;
    ch = nv ^ src_v;
    @(posedge sys_clk);
    src_v <= nv;
    #1;
    lat_m = lat_m | (ch & (nv | DUAL_EDGE_MASK) & ~{4'h0, sw_off, 9'h0});
  endtask

  task automatic wait_oe(input logic v, input int lim);
    n = 0;
    while (oe !== v && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask

  // Waits until the pin has rested longer than a full gap, so no pulse is pending.
  task automatic quiet();
    int k = 0;
    int m = 0;
    while (m < TO + 100 && k < 20000) begin
      @(posedge sys_clk);
      #1;
      k++;
      m = (oe === 1'b0) ? m + 1 : 0;
    end
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    srst = 1'b1;
    src_v = '0;
    en_v = MASK_RESET;
    lat_m = '0;
    sw_on = '0;
    sw_off = '0;
    allowed = 1'b1;
    init = 1'b1;
    reset_out_n = 1'b0;
    strap = 1'b1;
    seed = 32'hB7B8;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk({30'h0, oe, out_q}, 32'h0);
    chk({31'h0, cfg}, 32'h1);
    @(posedge sys_clk);
    strap <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk({31'h0, cfg}, 32'h0);
    @(posedge sys_clk);
    init <= 1'b0;
    reset_out_n <= 1'b1;
    strap <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk({31'h0, cfg}, 32'h0);
    set_src(15'h0001);
    wait_oe(1'b1, 8);
    chk({30'h0, oe, out_q}, 32'h2);
    t0 = cyc;
    set_src(15'h0005);
    rd(ADDR_WAKE);
    chk({31'h0, oe}, 32'h1);
    wait_oe(1'b0, 4000);
    chk({31'h0, (cyc - t0) inside {[2499:2506]}}, 32'h1);
    t0 = cyc;
    set_src(15'h0007);
    wait_oe(1'b1, 4000);
    chk({31'h0, (cyc - t0) inside {[2999:3008]}}, 32'h1);
    t0 = cyc;
    wait_oe(1'b0, 4000);
    chk({31'h0, (cyc - t0) inside {[2999:3005]}}, 32'h1);
    rd(ADDR_WAKE);
    quiet();
    set_src(15'h0000);
    en_v <= 15'h7FFE;
    set_src(15'h0001);
    wait_oe(1'b1, 50);
    chk({31'h0, oe}, 32'h0);
    rd(ADDR_WAKE);
    allowed <= 1'b0;
    set_src(15'h0009);
    wait_oe(1'b1, 50);
    chk({31'h0, oe}, 32'h0);
    allowed <= 1'b1;
    en_v <= MASK_RESET;
    rd(ADDR_WAKE);
    set_src(15'h0029);
    wait_oe(1'b1, 8);
    chk({31'h0, oe}, 32'h1);
    rd(ADDR_WAKE);
    rd(ADDR_FAIL_A);
    rd(ADDR_FAIL_A);
    set_src(15'h0009);
    rd(ADDR_FAIL_A);
    rd(ADDR_WAKE);
    quiet();
    sw_off <= 2'b01;
    set_src(15'h0209);
    wait_oe(1'b1, 50);
    chk({31'h0, oe}, 32'h0);
    sw_off <= 2'b00;
    @(posedge sys_clk);
    sw_on <= 2'b01;
    @(posedge sys_clk);
    sw_on <= 2'b00;
    lat_m[REG2_UV_IDX] = 1'b1;
    wait_oe(1'b1, 8);
    chk({31'h0, oe}, 32'h1);
    rd(ADDR_FAIL_B);
    rd(ADDR_FAIL_B);
    rd(ADDR_WAKE);
    quiet();
    set_src(15'h0009);
    wait_oe(1'b1, 8);
    chk({31'h0, oe}, 32'h1);
    rd(ADDR_FAIL_B);
    rd(ADDR_FAIL_B);
    quiet();
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      set_src({11'h0, seed[3:0]});
      rd(ADDR_WAKE, 3'h3);
      rd(ADDR_WAKE);
      rd(3'h5);
    end
    end_sim();
  end
endmodule
`default_nettype wire
